// ===== verilog/dsp_pwm.sv
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1 - duty spans zero to 63/64 active
// R2 - polarity zero with duty zero gives high
// R3 - first divider zero stops channel clocks
// R4 - enabled control write acts at once
// R5 - enabled duty write waits for period end
// R6 - disabled writes reach active registers immediately
// R7 - buffered updates commit together at period end
// R8 - duty read returns active value only
// R9 - polarity one active high, zero low
// R10 - first divider: off, one, eight, sixteen
// R11 - second divider divides by field plus one
// R12 - six-bit duty sets active portion
// R13 - nonzero first divider takes port pin
// R14 - reset leaves duty bits untouched
// R15 - reset clears first divider, output low
// R16 - wait mode keeps channels running
// R17 - stop mode freezes waveform mid-phase
// R18 - software writes duty before enabling
// R19 - period is 64 scaled clocks
// R20 - active while counter below duty
module dsp_pwm (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        stop_i,
  input  wire logic        gpio_a_data_i,
  input  wire logic        gpio_a_dir_i,
  input  wire logic        gpio_b_data_i,
  input  wire logic        gpio_b_dir_i,
  output logic             chan_a_port_pin_o,
  output logic             chan_a_port_pin_oe_o,
  output logic             chan_b_port_pin_o,
  output logic             chan_b_port_pin_oe_o,
  output logic             pwm_a_o,
  output logic             pwm_b_o
);

  // true when the aligned word address matches a register offset
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // first-stage rate select field of a control byte
  function automatic logic [1:0] first_of(input logic [5:0] ctrl);
    first_of = ctrl[dsp_pkg::FIRST_HI_BIT:dsp_pkg::FIRST_LO_BIT];
  endfunction

  dsp_pkg::dsp_bus_e bus_q;
  logic [31:0]       rdata_q;
  logic              req;
  logic              wr_fire;
  logic              mapped;

  // per channel state, index 0 is channel a and 1 is channel b
  logic [5:0]        ctrl_q      [2];
  logic [5:0]        buf_duty_q  [2];
  logic              buf_pol_q   [2];
  logic [5:0]        act_duty_q  [2];
  logic              act_pol_q   [2];
  logic              pend_q      [2];
  logic              pin_q       [2];
  logic              pin_oe_q    [2];
  logic              wave_q      [2];

  logic              en          [2];
  logic              wr_ctrl     [2];
  logic              wr_duty     [2];
  logic              period_end  [2];
  logic [5:0]        cnt         [2];
  logic              wave        [2];
  logic              gpio_data   [2];
  logic              gpio_dir    [2];
  logic [7:0]        wbyte;
  logic              run;

  // ------------------------------------------------------------------
  // wishbone classic slave
  // ------------------------------------------------------------------

  assign req    = wb_cyc_i && wb_stb_i;
  assign mapped = hit(wb_adr_i, dsp_pkg::CTRL_A_OFS) ||
                  hit(wb_adr_i, dsp_pkg::CTRL_B_OFS) ||
                  hit(wb_adr_i, dsp_pkg::DUTY_A_OFS) ||
                  hit(wb_adr_i, dsp_pkg::DUTY_B_OFS) ||
                  hit(wb_adr_i, dsp_pkg::STATUS_OFS) ||
                  hit(wb_adr_i, dsp_pkg::COUNT_OFS);

  // writes land on the edge where the master samples ack; only lane 0 holds data
  assign wr_fire = (bus_q == dsp_pkg::BUS_ACK) && req && wb_we_i &&
                   wb_sel_i[0] && mapped;
  assign wbyte   = wb_dat_i[7:0];
  assign wb_ack_o = (bus_q == dsp_pkg::BUS_ACK);
  assign wb_dat_o = rdata_q;

  // two-state handshake: one wait state, then ack for exactly one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_q <= dsp_pkg::BUS_IDLE;
    end else begin
      case (bus_q)
        dsp_pkg::BUS_IDLE: begin
          if (req) begin
            bus_q <= dsp_pkg::BUS_ACK;
          end
        end
        dsp_pkg::BUS_ACK: begin
          bus_q <= dsp_pkg::BUS_IDLE;
        end
        default: begin
          bus_q <= dsp_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // read data captured as the request is taken; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_q == dsp_pkg::BUS_IDLE && req) begin
      rdata_q <= 32'h0000_0000;
      if (hit(wb_adr_i, dsp_pkg::CTRL_A_OFS)) begin
        rdata_q[5:0] <= ctrl_q[0];
      end else if (hit(wb_adr_i, dsp_pkg::CTRL_B_OFS)) begin
        rdata_q[5:0] <= ctrl_q[1];
      end else if (hit(wb_adr_i, dsp_pkg::DUTY_A_OFS)) begin
        rdata_q[dsp_pkg::POL_BIT] <= act_pol_q[0];
        rdata_q[dsp_pkg::DUTY_MSB:dsp_pkg::DUTY_LSB] <= act_duty_q[0]; // R8
      end else if (hit(wb_adr_i, dsp_pkg::DUTY_B_OFS)) begin
        rdata_q[dsp_pkg::POL_BIT] <= act_pol_q[1];
        rdata_q[dsp_pkg::DUTY_MSB:dsp_pkg::DUTY_LSB] <= act_duty_q[1]; // R8
      end else if (hit(wb_adr_i, dsp_pkg::STATUS_OFS)) begin
        rdata_q[dsp_pkg::ST_EN_A_BIT]   <= en[0];
        rdata_q[dsp_pkg::ST_EN_B_BIT]   <= en[1];
        rdata_q[dsp_pkg::ST_PEND_A_BIT] <= pend_q[0];
        rdata_q[dsp_pkg::ST_PEND_B_BIT] <= pend_q[1];
        rdata_q[dsp_pkg::ST_STOP_BIT]   <= stop_i;
      end else if (hit(wb_adr_i, dsp_pkg::COUNT_OFS)) begin
        rdata_q[dsp_pkg::CNT_A_LSB +: 6] <= cnt[0];
        rdata_q[dsp_pkg::CNT_B_LSB +: 6] <= cnt[1];
      end
    end
  end

  // ------------------------------------------------------------------
  // per channel write strobes and enables
  // ------------------------------------------------------------------

  assign wr_ctrl[0] = wr_fire && hit(wb_adr_i, dsp_pkg::CTRL_A_OFS);
  assign wr_ctrl[1] = wr_fire && hit(wb_adr_i, dsp_pkg::CTRL_B_OFS);
  assign wr_duty[0] = wr_fire && hit(wb_adr_i, dsp_pkg::DUTY_A_OFS);
  assign wr_duty[1] = wr_fire && hit(wb_adr_i, dsp_pkg::DUTY_B_OFS);
  assign en[0]      = (first_of(ctrl_q[0]) != dsp_pkg::FIRST_OFF);
  assign en[1]      = (first_of(ctrl_q[1]) != dsp_pkg::FIRST_OFF);
  assign gpio_data[0] = gpio_a_data_i;
  assign gpio_data[1] = gpio_b_data_i;
  assign gpio_dir[0]  = gpio_a_dir_i;
  assign gpio_dir[1]  = gpio_b_dir_i;

  // stop freezes the counters; wait mode needs no input since nothing changes
  assign run = !stop_i; // R17 R16

  // control registers act at once whether or not the channel runs
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        ctrl_q[i][dsp_pkg::FIRST_HI_BIT:dsp_pkg::FIRST_LO_BIT] <= dsp_pkg::FIRST_RST; // R15
        ctrl_q[i][dsp_pkg::SECOND_MSB:dsp_pkg::SECOND_LSB] <= dsp_pkg::SECOND_RST;
      end else if (wr_ctrl[i]) begin
        ctrl_q[i] <= wbyte[5:0]; // R4 R6
      end
    end
  end

  // write buffer takes every duty write; it is never reset
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_duty[i]) begin
        buf_duty_q[i] <= wbyte[dsp_pkg::DUTY_MSB:dsp_pkg::DUTY_LSB]; // R14
      end
    end
  end

  // buffered polarity has a defined reset so a disabled pin is predictable
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        buf_pol_q[i] <= dsp_pkg::POL_RST;
      end else if (wr_duty[i]) begin
        buf_pol_q[i] <= wbyte[dsp_pkg::POL_BIT];
      end
    end
  end

  // pending flag: a write in the same cycle as the period end wins
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        pend_q[i] <= 1'b0;
      end else if (wr_duty[i] && en[i]) begin
        pend_q[i] <= 1'b1; // R5
      end else if (period_end[i] || !en[i]) begin
        pend_q[i] <= 1'b0; // R7
      end
    end
  end

  // active duty: direct when off, else only at a period boundary
  // duty data is left unreset, so a channel enabled first drives garbage
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (wr_duty[i] && !en[i]) begin
        act_duty_q[i] <= wbyte[dsp_pkg::DUTY_MSB:dsp_pkg::DUTY_LSB]; // R6 R14
      end else if (pend_q[i] && (period_end[i] || !en[i])) begin
        act_duty_q[i] <= buf_duty_q[i]; // R5 R7
      end
    end
  end

  // active polarity follows the same commit path as the duty
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        act_pol_q[i] <= dsp_pkg::POL_RST;
      end else if (wr_duty[i] && !en[i]) begin
        act_pol_q[i] <= wbyte[dsp_pkg::POL_BIT]; // R6
      end else if (pend_q[i] && (period_end[i] || !en[i])) begin
        act_pol_q[i] <= buf_pol_q[i]; // R7
      end
    end
  end

  // ------------------------------------------------------------------
  // channel engines
  // ------------------------------------------------------------------

  dsp_chan u_chan_a (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .run_i        (run),
    .first_div_i  (first_of(ctrl_q[0])),
    .second_div_i (ctrl_q[0][dsp_pkg::SECOND_MSB:dsp_pkg::SECOND_LSB]),
    .duty_i       (act_duty_q[0]),
    .pol_i        (act_pol_q[0]),
    .period_end_o (period_end[0]),
    .cnt_o        (cnt[0]),
    .wave_o       (wave[0])
  );

  dsp_chan u_chan_b (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .run_i        (run),
    .first_div_i  (first_of(ctrl_q[1])),
    .second_div_i (ctrl_q[1][dsp_pkg::SECOND_MSB:dsp_pkg::SECOND_LSB]),
    .duty_i       (act_duty_q[1]),
    .pol_i        (act_pol_q[1]),
    .period_end_o (period_end[1]),
    .cnt_o        (cnt[1]),
    .wave_o       (wave[1])
  );

  // ------------------------------------------------------------------
  // port pin ownership
  // ------------------------------------------------------------------

  // registered mux adds one cycle of lag but keeps the pin glitch free
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        pin_q[i]    <= 1'b0; // R15
        pin_oe_q[i] <= 1'b0;
      end else if (en[i]) begin
        pin_q[i]    <= wave[i]; // R13
        pin_oe_q[i] <= 1'b1;
      end else begin
        pin_q[i]    <= gpio_data[i]; // R13
        pin_oe_q[i] <= gpio_dir[i];
      end
    end
  end

  // raw waveform copies, low whenever the channel is off
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (rst_i) begin
        wave_q[i] <= 1'b0;
      end else begin
        wave_q[i] <= wave[i];
      end
    end
  end

  assign chan_a_port_pin_o    = pin_q[0];
  assign chan_a_port_pin_oe_o = pin_oe_q[0];
  assign chan_b_port_pin_o    = pin_q[1];
  assign chan_b_port_pin_oe_o = pin_oe_q[1];
  assign pwm_a_o              = wave_q[0];
  assign pwm_b_o              = wave_q[1];

endmodule

`default_nettype wire

// ===== pkg/dsp_pkg.sv
package dsp_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] CTRL_A_OFS  = 8'h00;
  localparam logic [7:0] CTRL_B_OFS  = 8'h04;
  localparam logic [7:0] DUTY_A_OFS  = 8'h08;
  localparam logic [7:0] DUTY_B_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] COUNT_OFS   = 8'h14;

  // control register fields
  localparam int FIRST_HI_BIT   = 5;
  localparam int FIRST_LO_BIT   = 4;
  localparam int SECOND_MSB     = 3;
  localparam int SECOND_LSB     = 0;

  // duty register fields
  localparam int POL_BIT        = 7;
  localparam int DUTY_MSB       = 5;
  localparam int DUTY_LSB       = 0;

  // status register fields
  localparam int ST_EN_A_BIT    = 0;
  localparam int ST_EN_B_BIT    = 1;
  localparam int ST_PEND_A_BIT  = 2;
  localparam int ST_PEND_B_BIT  = 3;
  localparam int ST_STOP_BIT    = 4;

  // count register fields
  localparam int CNT_A_LSB      = 0;
  localparam int CNT_B_LSB      = 8;

  // reset values
  localparam logic [1:0] FIRST_RST  = 2'h0;
  localparam logic [3:0] SECOND_RST = 4'h0;
  localparam logic       POL_RST    = 1'h0;

  // first-stage divider encodings and their terminal counts
  localparam logic [1:0] FIRST_OFF   = 2'h0;
  localparam logic [1:0] FIRST_DIV1  = 2'h1;
  localparam logic [1:0] FIRST_DIV8  = 2'h2;
  localparam logic [1:0] FIRST_DIV16 = 2'h3;
  localparam logic [3:0] DIV1_LAST   = 4'h0;
  localparam logic [3:0] DIV8_LAST   = 4'h7;
  localparam logic [3:0] DIV16_LAST  = 4'hf;

  // period counter terminal value
  localparam logic [5:0] CNT_LAST    = 6'h3f;

  // bus slave states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } dsp_bus_e;

endpackage

// ===== verilog/dsp_chan.sv
`timescale 1ns/1ps
`default_nettype none

module dsp_chan (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] first_div_i,
  input  wire logic [3:0] second_div_i,
  input  wire logic [5:0] duty_i,
  input  wire logic       pol_i,
  output logic            period_end_o,
  output logic [5:0]      cnt_o,
  output logic            wave_o
);

  logic [3:0] pre1_q;
  logic [3:0] pre2_q;
  logic [5:0] cnt_q;
  logic       wave_q;
  logic [3:0] pre1_last;
  logic       en;
  logic       tick1;
  logic       tick2;
  logic       active;

  // first-stage terminal count from the rate select field
  always_comb begin
    case (first_div_i)
      dsp_pkg::FIRST_DIV1:  pre1_last = dsp_pkg::DIV1_LAST; // R10
      dsp_pkg::FIRST_DIV8:  pre1_last = dsp_pkg::DIV8_LAST; // R10
      dsp_pkg::FIRST_DIV16: pre1_last = dsp_pkg::DIV16_LAST; // R10
      default:              pre1_last = dsp_pkg::DIV1_LAST;
    endcase
  end

  // ticks are enables, not clocks; >= keeps a shrunk ratio from running to wrap
  assign en     = (first_div_i != dsp_pkg::FIRST_OFF); // R3
  assign tick1  = en && run_i && (pre1_q >= pre1_last);
  assign tick2  = tick1 && (pre2_q >= second_div_i); // R11
  assign active = (cnt_q < duty_i); // R20 R1 R12
  assign period_end_o = tick2 && (cnt_q == dsp_pkg::CNT_LAST);
  assign cnt_o  = cnt_q;
  assign wave_o = wave_q;

  // first-stage prescaler, held clear while the channel is off
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      pre1_q <= 4'h0; // R3
    end else if (tick1) begin
      pre1_q <= 4'h0;
    end else if (run_i) begin
      pre1_q <= pre1_q + 4'h1;
    end
  end

  // second-stage prescaler divides by field plus one
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      pre2_q <= 4'h0;
    end else if (tick2) begin
      pre2_q <= 4'h0; // R11
    end else if (tick1) begin
      pre2_q <= pre2_q + 4'h1;
    end
  end

  // modulo-64 period counter, wraps 63 to 0 by overflow
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      cnt_q <= 6'h00;
    end else if (tick2) begin
      cnt_q <= cnt_q + 6'h01; // R19 R20
    end
  end

  // waveform; a stopped clock freezes it in whatever phase it was
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      wave_q <= 1'b0; // R15
    end else if (run_i) begin
      wave_q <= pol_i ? active : !active; // R9 R2 R17
    end
  end

endmodule

`default_nettype wire

// ===== tb/dsp_pwm_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        stop_i,
  input wire logic        gpio_a_data_i,
  input wire logic        gpio_a_dir_i,
  input wire logic        chan_a_port_pin_o,
  input wire logic        chan_a_port_pin_oe_o,
  input wire logic        chan_b_port_pin_o,
  input wire logic        chan_b_port_pin_oe_o,
  input wire logic        pwm_a_o,
  input wire logic        pwm_b_o
);
  logic en_a_q;
  logic en_b_q;
  logic wr_ok;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // enable mirror; a write lands at the edge that samples ack
  assign wr_ok = wb_ack_o & wb_we_i & wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_a_q <= 1'b0;
      en_b_q <= 1'b0;
    end else if (wr_ok && wb_adr_i[7:2] == 6'h00) begin
      en_a_q <= |wb_dat_i[5:4];
    end else if (wr_ok && wb_adr_i[7:2] == 6'h01) begin
      en_b_q <= |wb_dat_i[5:4];
    end
  end

  sequence req_s;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  // three stopped edges: wave and its output register both frozen
  sequence frozen_s;
    stop_i [*3];
  endsequence

  ack_timing_a: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_unmapped_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h05
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  pin_gpio_a: assert property (!$past(rst_i) && !$past(en_a_q) |->
    chan_a_port_pin_o == $past(gpio_a_data_i) && chan_a_port_pin_oe_o == $past(gpio_a_dir_i))
    else $error("pin a not port logic");
  pin_wave_a: assert property ($past(en_a_q) |->
    chan_a_port_pin_oe_o && chan_a_port_pin_o == pwm_a_o) else $error("pin a not wave");
  pin_wave_b_a: assert property ($past(en_b_q) |->
    chan_b_port_pin_oe_o && chan_b_port_pin_o == pwm_b_o) else $error("pin b not wave");
  off_low_a: assert property (!en_a_q && !$past(en_a_q) && !$past(en_a_q, 2) |-> !pwm_a_o)
    else $error("wave a while off");
  stop_hold_a: assert property (frozen_s |-> $stable(pwm_a_o) && $stable(pwm_b_o))
    else $error("wave moved in stop");
endmodule

bind dsp_pwm dsp_pwm_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_i, .gpio_a_data_i,
  .gpio_a_dir_i, .chan_a_port_pin_o, .chan_a_port_pin_oe_o, .chan_b_port_pin_o,
  .chan_b_port_pin_oe_o, .pwm_a_o, .pwm_b_o);

`default_nettype wire

// ===== tb/dsp_pwm_tb.sv
`timescale 1ns/1ps
`default_nettype none

module dsp_pwm_tb;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        stop_i;
  logic [1:0]  gd_q;
  logic [1:0]  gr_q;
  logic [1:0]  pin_o;
  logic [1:0]  oe_o;
  logic [1:0]  pwm_o;
  logic [31:0] rd;
  logic [31:0] hold;
  int          err_total;
  int          num_checks;
  int          n;
  logic [7:0]  dt [5] = '{8'h00, 8'h80, 8'hbf, 8'h90, 8'h10};
  int          ot [5] = '{128, 0, 126, 32, 96};
  logic [7:0]  ct [4] = '{8'h12, 8'h22, 8'h32, 8'h1f};
  int          pt [4] = '{192, 1536, 3072, 1024};

  dsp_pwm dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_i(stop_i),
    .gpio_a_data_i(gd_q[0]), .gpio_a_dir_i(gr_q[0]), .gpio_b_data_i(gd_q[1]),
    .gpio_b_dir_i(gr_q[1]), .chan_a_port_pin_o(pin_o[0]), .chan_a_port_pin_oe_o(oe_o[0]),
    .chan_b_port_pin_o(pin_o[1]), .chan_b_port_pin_oe_o(oe_o[1]),
    .pwm_a_o(pwm_o[0]), .pwm_b_o(pwm_o[1]));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= dat;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_total++;
      test_done();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // cycles between two rising edges of one output
  task automatic period(input int ch, output int cyc);
    logic p;
    int   k;
    int   r;
    p = pwm_o[ch];
    r = 0;
    k = 0;
    cyc = 0;
    while (r < 2 && k < 20000) begin
      @(posedge clk_i);
      k++;
      if (r == 1) cyc++;
      if (p === 1'b0 && pwm_o[ch] === 1'b1) r++;
      p = pwm_o[ch];
    end
    if (r < 2) begin
      err_total++;
      test_done();
    end
  endtask

  // high cycles over two full 64-clock periods, after the pipeline settles
  task automatic ones(input int ch, output int cnt);
    cnt = 0;
    repeat (4) @(posedge clk_i);
    repeat (128) begin
      @(posedge clk_i);
      if (pwm_o[ch] === 1'b1) cnt++;
    end
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    stop_i = 1'b0;
    gd_q = 2'b01;
    gr_q = 2'b11;
    err_total = 0;
    num_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset state of both channels and their pins
    for (int ch = 0; ch < 2; ch++) begin
      bus(1'b0, 8'(4 * ch), 32'h0000_0000);
      chk("ctrl", rd, 32'h0000_0000);
    end
    chk("pwm", 32'(pwm_o), 32'h0000_0000);
    chk("pins", 32'({oe_o, pin_o}), 32'({gr_q, gd_q}));
    bus(1'b1, 8'h18, 32'h0000_00ff);
    bus(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    // duty and polarity levels; duty written while off, before enabling
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 5; i++) begin
        bus(1'b1, 8'(4 * ch), 32'h0000_0000);
        bus(1'b1, 8'(8 + 4 * ch), 32'(dt[i]));
        bus(1'b0, 8'(8 + 4 * ch), 32'h0000_0000);
        chk("duty", rd, 32'(dt[i]));
        bus(1'b1, 8'(4 * ch), 32'h0000_0010);
        ones(ch, n);
        chk("ones", n, ot[i]);
      end
      // each enabled first-stage code, and second-stage fields of 2 and 15
      for (int i = 0; i < 4; i++) begin
        bus(1'b1, 8'(4 * ch), 32'(ct[i]));
        period(ch, n);
        chk("period", n, pt[i]);
      end
    end
    // enabled duty write waits for the period end, slowest rate
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_0090);
    bus(1'b1, 8'h00, 32'h0000_003f);
    bus(1'b1, 8'h08, 32'h0000_00b0);
    bus(1'b0, 8'h08, 32'h0000_0000);
    chk("buffered", rd, 32'h0000_0090);
    n = 0;
    do begin
      bus(1'b0, 8'h10, 32'h0000_0000);
      n++;
    end while (rd[2] === 1'b1 && n < 8000);
    if (rd[2] === 1'b1) begin
      err_total++;
      test_done();
    end
    bus(1'b0, 8'h08, 32'h0000_0000);
    chk("committed", rd, 32'h0000_00b0);
    // control write acts at once: the long period must not finish first
    bus(1'b1, 8'h00, 32'h0000_0010);
    // the counter must step every clock from the very next edge, 13 edges apart
    bus(1'b0, 8'h14, 32'h0000_0000);
    hold = rd;
    repeat (10) @(posedge clk_i);
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk("count step", 32'(6'(rd[5:0] - hold[5:0])), 32'h0000_000d);
    period(0, n);
    chk("period now", n, 64);
    // stop freezes the counters
    stop_i <= 1'b1;
    bus(1'b0, 8'h14, 32'h0000_0000);
    hold = rd;
    repeat (20) @(posedge clk_i);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk("status", rd, 32'h0000_0013);
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk("frozen", rd, hold);
    stop_i <= 1'b0;
    // shut off: output low, pin back to port logic
    bus(1'b1, 8'h00, 32'h0000_0000);
    // new port values, so a pin stuck on the old ones shows up
    gd_q <= 2'b10;
    gr_q <= 2'b10;
    repeat (3) @(posedge clk_i);
    chk("off wave", 32'(pwm_o[0]), 32'h0000_0000);
    chk("off pin", 32'({oe_o[0], pin_o[0]}), 32'({gr_q[0], gd_q[0]}));
    // a second reset keeps the duty but clears the divider
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 8'h08, 32'h0000_0000);
    chk("duty kept", 32'(rd[5:0]), 32'h0000_0030);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl cleared", rd, 32'h0000_0000);
    test_done();
  end
endmodule

`default_nettype wire
